// ### include/ufc_pkg.sv
`default_nettype none
package ufc_pkg;
  // ****************************************************************
  // Register indices; the byte address on the bus is four times these.
  // ****************************************************************
  localparam logic [7:0] IDX_DATA0 = 8'h90;
  localparam logic [7:0] IDX_DATA3 = 8'h93;
  localparam logic [7:0] IDX_DIV_LO = 8'h94;
  localparam logic [7:0] IDX_DIV_HI = 8'h95;
  localparam logic [7:0] IDX_BAUD = 8'h96;
  localparam logic [7:0] IDX_LINE = 8'h97;
  localparam logic [7:0] IDX_RTS = 8'h98;
  localparam logic [7:0] IDX_THR = 8'h99;
  localparam logic [7:0] IDX_TO_BASE = 8'h9a;
  localparam logic [7:0] IDX_TO_MODE = 8'h9b;
  localparam logic [7:0] IDX_FILL = 8'h9c;
  localparam logic [7:0] IDX_BUF = 8'h9d;
  localparam logic [7:0] IDX_EVT = 8'h9e;
  localparam logic [7:0] IDX_FSM = 8'h9f;
  // ****************************************************************
  // Reset values.
  // ****************************************************************
  localparam logic [7:0] RST_DIV_LO = 8'hff;
  localparam logic [7:0] RST_DIV_HI = 8'h0f;
  localparam logic [7:0] RST_BAUD = 8'h0f;
  localparam logic [7:0] RST_LINE = 8'h0e;
  localparam logic [7:0] RST_RTS = 8'ha5;
  localparam logic [7:0] RST_THR = 8'h44;
  localparam logic [7:0] RST_TO_BASE = 8'hc0;
  localparam logic [7:0] RST_TO_MODE = 8'h01;
  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int DIV_EN_BIT = 7;
  localparam int BAUD_RX_DMA = 4;
  localparam int BAUD_TX_DMA = 5;
  localparam int BAUD_RX_IE = 6;
  localparam int BAUD_TX_IE = 7;
  localparam int LINE_CTS_INV = 0;
  localparam int LINE_CTS_EN = 1;
  localparam int LINE_PAR_EN = 2;
  localparam int LINE_PAR_ODD = 3;
  localparam int LINE_STOP_LO = 4;
  localparam int LINE_INVERT = 6;
  localparam int LINE_LOOP = 7;
  localparam int RTS_POL = 4;
  localparam int RTS_MAN_VAL = 5;
  localparam int RTS_MAN_EN = 6;
  localparam int RTS_EN = 7;
  localparam int MODE_SMART_CARD = 5;
  localparam int MODE_MASK_TXDONE = 6;
  localparam int MODE_MASK_ERR = 7;
  localparam int BUF_CLR_RX = 6;
  localparam int BUF_CLR_TX = 7;
  localparam int FIFO_DEPTH = 4;
  // ****************************************************************
  // Timing and states.
  // ****************************************************************
  localparam int BUS_WAIT_CYCLES = 1;
  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ufc_tx_state_t;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ufc_rx_state_t;
endpackage
`default_nettype wire

// ### hw/ufc_uart.sv
`timescale 1ns/1ns
`default_nettype none
//Contract
// - Data window writes push, reads pop.
// - Working clock is sysclk over divider+1.
// - Bit period is width count plus one.
// - Control bits enable DMA and interrupts.
// - Clear-to-send stalls transmitter when enabled.
// - Clear-to-send polarity is selectable.
// - Optional parity, even or odd.
// - Stop length one, one and a half, two.
// - Stop code 00, 01, 1x.
// - Invert option flips both lines.
// - Request-to-send raised near full receive.
// - Request-to-send enable, trigger level, polarity.
// - Manual override drives request-to-send value.
// - Buffer count thresholds raise interrupts.
// - Timeout base counts working clocks.
// - Two-bit multiplier scales timeout base.
// - Line gap past timeout ends transaction.
// - Fill counts readable in one register.
// - Write one clears receive side.
// - Bit seven reads error, clears transmit.
module ufc_uart (
  input wire logic clk,
  input wire logic reset,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic tx_pin,
  input wire logic rx_pin,
  input wire logic cts_pin,
  output logic rts_pin,
  input wire logic trx_in,
  output logic trx_out,
  output logic trx_oe,
  output logic smart_card_mode_enable,
  output logic rx_dma_req,
  output logic tx_dma_req,
  output logic rx_dma_eot,
  output logic irq
);
  import ufc_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Working clocks per bit; the width field is expected to be above two.
  function automatic logic [5:0] bit_len(input logic [3:0] bw);
    bit_len = {2'b00, bw} + 6'h01;
  endfunction

  // Stop length in working clocks for the two-bit stop code.
  function automatic logic [5:0] stop_len(input logic [3:0] bw, input logic [1:0] code);
    logic [5:0] bl;
    bl = bit_len(bw);
    if (code[1]) begin
      stop_len = {bl[4:0], 1'b0};
    end else if (code[0]) begin
      stop_len = bl + {1'b0, bl[5:1]};
    end else begin
      stop_len = bl;
    end
  endfunction

  logic [7:0] div_lo, div_hi, baud_ctl, line_ctl, rts_ctl, thr, to_base, to_mode;
  logic ack_q, req, wr_go, rd_go;
  logic [7:0] idx, rd_val;
  logic is_data, tx_push, rx_pop, clr_rx, clr_tx;
  logic [7:0] tx_mem [FIFO_DEPTH];
  logic [7:0] rx_mem [FIFO_DEPTH];
  logic [1:0] tx_wp, tx_rp, rx_wp, rx_rp;
  logic [2:0] tx_cnt, rx_cnt;
  logic tx_pop, rx_push, rx_err, txdone, rxdone;
  logic [2:0] sync1, sync2, sync3, pin_f;
  logic [14:0] div_cnt;
  logic tick;
  ufc_tx_state_t tx_state;
  ufc_rx_state_t rx_state;
  logic [5:0] tcnt, rcnt;
  logic [2:0] tbit, rbit;
  logic [7:0] tsh, rsh;
  logic tx_line, rx_src, cts_block, rx_ok_par, rx_err_set;
  logic [9:0] idle_cnt, to_limit;
  logic armed, timeout;
  logic tx_buf_irq, rx_buf_irq, rts_near_full;

  // ****************************************************************
  // Avalon-MM slave
  // ****************************************************************
  // One wait cycle per access, so read data can be registered before release.
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign wr_go = avs_write & ack_q & avs_byteenable[0];
  assign rd_go = avs_read & ack_q;
  assign idx = avs_address[9:2];
  assign is_data = (idx >= IDX_DATA0) && (idx <= IDX_DATA3);
  assign tx_push = wr_go & is_data & (tx_cnt != 3'(FIFO_DEPTH));
  assign rx_pop = rd_go & is_data & (rx_cnt != 3'h0);
  assign clr_rx = wr_go & (idx == IDX_BUF) & avs_writedata[BUF_CLR_RX];
  assign clr_tx = wr_go & (idx == IDX_BUF) & avs_writedata[BUF_CLR_TX];

  // Acknowledge toggles so that back-to-back requests each see one wait cycle.
  always_ff @(posedge clk) begin
    if (reset) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // Read mux; unmapped indices read as zero.
  always_comb begin
    rd_val = 8'h00;
    case (idx)
      IDX_DATA0, 8'h91, 8'h92, IDX_DATA3: rd_val = rx_mem[rx_rp];
      IDX_DIV_LO: rd_val = div_lo;
      IDX_DIV_HI: rd_val = div_hi;
      IDX_BAUD: rd_val = baud_ctl;
      IDX_LINE: rd_val = line_ctl;
      IDX_RTS: rd_val = rts_ctl;
      IDX_THR: rd_val = thr;
      IDX_TO_BASE: rd_val = to_base;
      IDX_TO_MODE: rd_val = to_mode;
      IDX_FILL: rd_val = {1'b0, tx_cnt, 1'b0, rx_cnt};
      IDX_BUF: rd_val = {rx_err, tx_cnt, irq, rx_cnt};
      IDX_EVT: rd_val = {4'h0, rx_buf_irq, rxdone, tx_buf_irq, txdone};
      IDX_FSM: rd_val = {1'b0, 3'(rx_state), 1'b0, 3'(tx_state)};
      default: rd_val = 8'h00;
    endcase
  end

  // Read data is captured in the wait cycle and stands at the release edge.
  always_ff @(posedge clk) begin
    if (reset) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~ack_q) begin
      avs_readdata <= {24'h00_0000, rd_val};
    end
  end

  // Configuration registers.
  always_ff @(posedge clk) begin
    if (reset) begin
      div_lo <= RST_DIV_LO;
      div_hi <= RST_DIV_HI;
      baud_ctl <= RST_BAUD;
      line_ctl <= RST_LINE;
      rts_ctl <= RST_RTS;
      thr <= RST_THR;
      to_base <= RST_TO_BASE;
      to_mode <= RST_TO_MODE;
    end else if (wr_go) begin
      case (idx)
        IDX_DIV_LO: div_lo <= avs_writedata[7:0];
        IDX_DIV_HI: div_hi <= avs_writedata[7:0];
        IDX_BAUD: baud_ctl <= avs_writedata[7:0];
        IDX_LINE: line_ctl <= avs_writedata[7:0];
        IDX_RTS: rts_ctl <= avs_writedata[7:0];
        IDX_THR: thr <= avs_writedata[7:0];
        IDX_TO_BASE: to_base <= avs_writedata[7:0];
        IDX_TO_MODE: to_mode <= avs_writedata[7:0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Buffers
  // ****************************************************************
  // Transmit buffer; a clear drops queued bytes but lets the current frame end.
  always_ff @(posedge clk) begin
    if (reset | clr_tx) begin
      tx_wp <= 2'h0;
      tx_rp <= 2'h0;
      tx_cnt <= 3'h0;
    end else begin
      if (tx_push) begin
        tx_mem[tx_wp] <= avs_writedata[7:0];
        tx_wp <= tx_wp + 2'h1;
      end
      if (tx_pop) begin
        tx_rp <= tx_rp + 2'h1;
      end
      tx_cnt <= tx_cnt + {2'b00, tx_push} - {2'b00, tx_pop};
    end
  end

  // Receive buffer; a byte arriving while full is dropped and flags an error.
  always_ff @(posedge clk) begin
    if (reset | clr_rx) begin
      rx_wp <= 2'h0;
      rx_rp <= 2'h0;
      rx_cnt <= 3'h0;
    end else begin
      if (rx_push) begin
        rx_mem[rx_wp] <= rsh;
        rx_wp <= rx_wp + 2'h1;
      end
      if (rx_pop) begin
        rx_rp <= rx_rp + 2'h1;
      end
      rx_cnt <= rx_cnt + {2'b00, rx_push} - {2'b00, rx_pop};
    end
  end

  // ****************************************************************
  // Pins and clocking
  // ****************************************************************
  // Three-stage synchronisers; a change counts once stages two and three agree.
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1 <= 3'h5;
      sync2 <= 3'h5;
      sync3 <= 3'h5;
      pin_f <= 3'h5;
    end else begin
      sync1 <= {trx_in, cts_pin, rx_pin};
      sync2 <= sync1;
      sync3 <= sync2;
      pin_f <= ((sync2 ~^ sync3) & sync3) | ((sync2 ^ sync3) & pin_f);
    end
  end

  // Working-clock enable; with the divider off it runs at the system rate.
  always_ff @(posedge clk) begin
    if (reset) begin
      div_cnt <= 15'h0000;
    end else if (!div_hi[DIV_EN_BIT] || tick) begin
      div_cnt <= 15'h0000;
    end else begin
      div_cnt <= div_cnt + 15'h0001;
    end
  end
  assign tick = !div_hi[DIV_EN_BIT] || (div_cnt == {div_hi[6:0], div_lo});

  assign cts_block = line_ctl[LINE_CTS_EN] & (pin_f[1] ^ line_ctl[LINE_CTS_INV]);
  assign smart_card_mode_enable = to_mode[MODE_SMART_CARD];
  // Loopback takes the raw transmit level, before any inversion.
  assign rx_src = line_ctl[LINE_LOOP] ? tx_line :
                  ((smart_card_mode_enable ? pin_f[2] : pin_f[0]) ^ line_ctl[LINE_INVERT]);

  // ****************************************************************
  // Transmitter
  // ****************************************************************
  assign tx_pop = (tx_state == TX_IDLE) && tick && (tx_cnt != 3'h0) && !cts_block;

  // Frame sequencer: start, eight data bits LSB first, optional parity, stop.
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_state <= TX_IDLE;
      tcnt <= 6'h00;
      tbit <= 3'h0;
      tsh <= 8'h00;
      tx_line <= 1'b1;
    end else if (tx_pop) begin
      tx_state <= TX_START;
      tsh <= tx_mem[tx_rp];
      tcnt <= 6'h00;
      tx_line <= 1'b0;
    end else if (tick && tx_state != TX_IDLE) begin
      tcnt <= tcnt + 6'h01;
      case (tx_state)
        TX_START, TX_DATA, TX_PAR: begin
          if (tcnt == bit_len(baud_ctl[3:0]) - 6'h01) begin
            tcnt <= 6'h00;
            if (tx_state == TX_START || (tx_state == TX_DATA && tbit != 3'h7)) begin
              tbit <= (tx_state == TX_START) ? 3'h0 : tbit + 3'h1;
              tx_state <= TX_DATA;
              tx_line <= (tx_state == TX_START) ? tsh[0] : tsh[tbit + 3'h1];
            end else if (tx_state == TX_DATA && line_ctl[LINE_PAR_EN]) begin
              tx_state <= TX_PAR;
              tx_line <= (^tsh) ^ line_ctl[LINE_PAR_ODD];
            end else begin
              tx_state <= TX_STOP;
              tx_line <= 1'b1;
            end
          end
        end
        TX_STOP: begin
          if (tcnt == stop_len(baud_ctl[3:0], line_ctl[5:4]) - 6'h01) begin
            tx_state <= TX_IDLE;
            tcnt <= 6'h00;
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // Registered line drivers; smart-card mode drives the shared line low only.
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_pin <= 1'b1;
      trx_out <= 1'b0;
      trx_oe <= 1'b0;
    end else begin
      tx_pin <= tx_line ^ line_ctl[LINE_INVERT];
      trx_out <= 1'b0;
      trx_oe <= smart_card_mode_enable & ~(tx_line ^ line_ctl[LINE_INVERT]);
    end
  end

  // ****************************************************************
  // Receiver
  // ****************************************************************
  assign rx_ok_par = (^rsh) ^ line_ctl[LINE_PAR_ODD];

  // Samples each bit at mid period after confirming the start bit.
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_state <= RX_IDLE;
      rcnt <= 6'h00;
      rbit <= 3'h0;
      rsh <= 8'h00;
      rx_push <= 1'b0;
    end else begin
      rx_push <= 1'b0;
      if (tick) begin
        rcnt <= rcnt + 6'h01;
        case (rx_state)
          RX_IDLE: begin
            rcnt <= 6'h00;
            if (!rx_src) begin
              rx_state <= RX_START;
            end
          end
          RX_START: begin
            if (rcnt == (bit_len(baud_ctl[3:0]) >> 1) - 6'h01) begin
              rcnt <= 6'h00;
              rbit <= 3'h0;
              rx_state <= rx_src ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            if (rcnt == bit_len(baud_ctl[3:0]) - 6'h01) begin
              rcnt <= 6'h00;
              rsh <= {rx_src, rsh[7:1]};
              rbit <= rbit + 3'h1;
              if (rbit == 3'h7) begin
                rx_state <= line_ctl[LINE_PAR_EN] ? RX_PAR : RX_STOP;
              end
            end
          end
          RX_PAR: begin
            if (rcnt == bit_len(baud_ctl[3:0]) - 6'h01) begin
              rcnt <= 6'h00;
              rx_state <= RX_STOP;
            end
          end
          RX_STOP: begin
            if (rcnt == bit_len(baud_ctl[3:0]) - 6'h01) begin
              rx_state <= RX_IDLE;
              rx_push <= (rx_cnt != 3'(FIFO_DEPTH));
            end
          end
          default: rx_state <= RX_IDLE;
        endcase
      end
    end
  end

  // Error flag: parity, framing or overrun; the set wins over a clear.
  assign rx_err_set = tick && rcnt == bit_len(baud_ctl[3:0]) - 6'h01 &&
                      ((rx_state == RX_PAR && rx_src != rx_ok_par) ||
                       (rx_state == RX_STOP && (!rx_src || rx_cnt == 3'(FIFO_DEPTH))));
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_err <= 1'b0;
    end else if (rx_err_set) begin
      rx_err <= 1'b1;
    end else if (clr_rx) begin
      rx_err <= 1'b0;
    end
  end

  // ****************************************************************
  // Idle timeout and events
  // ****************************************************************
  always_comb begin
    case (to_mode[1:0])
      2'b00: to_limit = {2'b00, to_base};
      2'b01: to_limit = {1'b0, to_base, 1'b0};
      2'b10: to_limit = {1'b0, to_base, 1'b0} + {2'b00, to_base};
      default: to_limit = {to_base, 2'b00};
    endcase
  end
  assign timeout = tick && armed && (idle_cnt >= to_limit);

  // Idle gap counted in working clocks, armed by a received byte.
  always_ff @(posedge clk) begin
    if (reset) begin
      idle_cnt <= 10'h000;
      armed <= 1'b0;
    end else begin
      if (rx_push) begin
        armed <= 1'b1;
      end else if (timeout) begin
        armed <= 1'b0;
      end
      if (rx_state != RX_IDLE || !rx_src || rx_push) begin
        idle_cnt <= 10'h000;
      end else if (tick && idle_cnt != 10'h3ff) begin
        idle_cnt <= idle_cnt + 10'h001;
      end
    end
  end

  // Done flags; a transmit push clears txdone, a receive pop or clear clears rxdone, but a same-cycle set wins.
  always_ff @(posedge clk) begin
    if (reset) begin
      txdone <= 1'b0;
      rxdone <= 1'b0;
      rx_dma_eot <= 1'b0;
    end else begin
      if (tick && tx_state == TX_STOP && tx_cnt == 3'h0 &&
          tcnt == stop_len(baud_ctl[3:0], line_ctl[5:4]) - 6'h01) begin
        txdone <= 1'b1;
      end else if (tx_push) begin
        txdone <= 1'b0;
      end
      if (timeout) begin
        rxdone <= 1'b1;
      end else if (rx_pop | clr_rx) begin
        rxdone <= 1'b0;
      end
      rx_dma_eot <= timeout & baud_ctl[BAUD_RX_DMA];
    end
  end

  assign rx_buf_irq = ({1'b0, rx_cnt} >= thr[3:0]);
  assign tx_buf_irq = ({1'b0, tx_cnt} <= thr[7:4]);
  assign rx_dma_req = baud_ctl[BAUD_RX_DMA] & (rx_cnt != 3'h0);
  assign tx_dma_req = baud_ctl[BAUD_TX_DMA] & (tx_cnt != 3'(FIFO_DEPTH));
  assign irq = (baud_ctl[BAUD_RX_IE] & rx_buf_irq) | (baud_ctl[BAUD_TX_IE] & tx_buf_irq) |
               (txdone & ~to_mode[MODE_MASK_TXDONE]) | (rx_err & ~to_mode[MODE_MASK_ERR]);

  // Flow-control output, registered so the pin never glitches.
  assign rts_near_full = ({1'b0, rx_cnt} >= rts_ctl[3:0]);
  always_ff @(posedge clk) begin
    if (reset) begin
      rts_pin <= 1'b0;
    end else if (!rts_ctl[RTS_EN]) begin
      rts_pin <= rts_ctl[RTS_POL];
    end else if (rts_ctl[RTS_MAN_EN]) begin
      rts_pin <= rts_ctl[RTS_MAN_VAL];
    end else begin
      rts_pin <= rts_near_full ^ rts_ctl[RTS_POL];
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_wait_one: assert property (@(posedge clk) disable iff (reset)
    $rose(req) |-> avs_waitrequest ##1 !avs_waitrequest) else $error("wait not one cycle");
  a_push_count: assert property (@(posedge clk) disable iff (reset)
    tx_push && !tx_pop && !clr_tx |=> tx_cnt == $past(tx_cnt) + 3'h1) else $error("push lost");
  a_pop_count: assert property (@(posedge clk) disable iff (reset)
    rx_pop && !rx_push && !clr_rx |=> rx_cnt == $past(rx_cnt) - 3'h1) else $error("pop lost");
  a_div_off_tick: assert property (@(posedge clk) disable iff (reset)
    !div_hi[DIV_EN_BIT] |-> tick) else $error("tick missing with divider off");
  a_cts_hold: assert property (@(posedge clk) disable iff (reset)
    cts_block && tx_state == TX_IDLE |=> tx_state == TX_IDLE) else $error("sent under cts");
  a_start_low: assert property (@(posedge clk) disable iff (reset)
    tx_state == TX_START |=> tx_pin == line_ctl[LINE_INVERT]) else $error("start level wrong");
  a_rts_manual: assert property (@(posedge clk) disable iff (reset)
    rts_ctl[RTS_EN] && rts_ctl[RTS_MAN_EN] |=> rts_pin == $past(rts_ctl[RTS_MAN_VAL]))
    else $error("rts manual ignored");
  a_clear_rx: assert property (@(posedge clk) disable iff (reset)
    clr_rx && !rx_err_set |=> rx_cnt == 3'h0 && !rx_err) else $error("rx clear failed");
  a_timeout_done: assert property (@(posedge clk) disable iff (reset)
    timeout |=> rxdone && !armed) else $error("timeout not flagged");
  c_tx_frame: cover property (@(posedge clk) disable iff (reset) tx_state == TX_STOP ##1 tx_state == TX_IDLE);
  c_rx_byte: cover property (@(posedge clk) disable iff (reset) rx_push);
  c_timeout: cover property (@(posedge clk) disable iff (reset) timeout);
  c_cts_stall: cover property (@(posedge clk) disable iff (reset) cts_block && tx_cnt != 3'h0);
endmodule
`default_nettype wire

// ### testbench/ufc_remote.sv
`timescale 1ns/1ns
`default_nettype none
module ufc_remote #(
  parameter int BIT = 16
) (
  input wire logic clk,
  input wire logic tx_pin,
  output logic rx_pin,
  output logic cts_pin
);
  // ****************************************************************
  // Remote serial device with a nearly-full signal toward the device.
  // ****************************************************************
  logic stop_sender = 1'b0;
  logic [7:0] got = 8'h00;
  logic [7:0] n_got = 8'h00;
  // Level seen in the slot after the data: parity if enabled, else the stop bit.
  logic last = 1'b0;
  // High asks the device to hold off; the bench raises it to stall the sender.
  assign cts_pin = stop_sender;
  initial rx_pin = 1'b1;
  // Mid-bit sampling, LSB first, so slow edges on the line do not matter.
  always begin
    @(negedge tx_pin);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk);
      got[i] = tx_pin;
    end
    repeat (BIT) @(posedge clk);
    last = tx_pin;
    n_got = n_got + 8'h01;
  end
  // Sends start, eight data bits and one stop bit, idle high afterwards.
  task automatic send(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      rx_pin <= frame[i];
      repeat (BIT - 1) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// ### testbench/uart_fifo_flow_control_bench.sv
`timescale 1ns/1ns
`default_nettype none
module uart_fifo_flow_control_bench;
  import ufc_pkg::*;
  // ****************************************************************
  // Stimulus, checking and verdict.
  // ****************************************************************
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, tx_pin, rx_pin, cts_pin, rts_pin, irq, trx_oe, sc_en;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;
  logic [7:0] rd;
  ufc_uart DUT (.clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tx_pin(tx_pin),
    .rx_pin(rx_pin), .cts_pin(cts_pin), .rts_pin(rts_pin), .trx_in(rx_pin), .trx_out(),
    .trx_oe(trx_oe), .smart_card_mode_enable(sc_en), .rx_dma_req(), .tx_dma_req(),
    .rx_dma_eot(), .irq(irq));
  ufc_remote remote (.clk(clk), .tx_pin(tx_pin), .rx_pin(rx_pin), .cts_pin(cts_pin));
  always #5 clk = ~clk;
  // A hang is cut short well past the few thousand cycles the run needs.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // One bus cycle; held until waitrequest is seen low at a rising edge.
  task automatic access(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                        output logic [7:0] d);
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h000000, wd};
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wait_frame(input logic [7:0] n0);
    for (int i = 0; i < 400 && remote.n_got == n0; i++) @(posedge clk);
  endtask
  task automatic reset_values();
    logic [7:0] idx [9] = '{IDX_DIV_LO, IDX_DIV_HI, IDX_BAUD, IDX_LINE, IDX_RTS, IDX_THR,
                            IDX_TO_BASE, IDX_TO_MODE, IDX_FILL};
    logic [7:0] val [9] = '{8'hff, 8'h0f, 8'h0f, 8'h0e, 8'ha5, 8'h44, 8'hc0, 8'h01, 8'h00};
    access(1'b1, IDX_FILL, 8'hff, rd);
    for (int i = 0; i < 9; i++) begin
      access(1'b0, idx[i], 8'h00, rd);
      check(rd, val[i]);
    end
  endtask
  task automatic tx_frame();
    logic [7:0] n0;
    n0 = remote.n_got;
    access(1'b1, IDX_LINE, 8'h00, rd);
    access(1'b1, IDX_DATA3, 8'ha5, rd);
    wait_frame(n0);
    check(remote.got, 8'ha5);
    check({7'h00, remote.last}, 8'h01);
    // Even parity over a5 is zero, so the slot after the data now reads low.
    n0 = remote.n_got;
    access(1'b1, IDX_LINE, 8'h04, rd);
    access(1'b1, IDX_DATA0, 8'ha5, rd);
    wait_frame(n0);
    check(remote.got, 8'ha5);
    check({7'h00, remote.last}, 8'h00);
    // Let the stop bit end: transmit done and buffer-low flags, done raises irq.
    repeat (30) @(posedge clk);
    access(1'b0, IDX_EVT, 8'h00, rd);
    check(rd, 8'h03);
    check({7'h00, irq}, 8'h01);
  endtask
  task automatic cts_hold();
    logic [7:0] n0;
    n0 = remote.n_got;
    // Stop is raised first, since the pin filter needs four edges to pass it.
    remote.stop_sender <= 1'b1;
    access(1'b1, IDX_LINE, 8'h02, rd);
    access(1'b1, IDX_DATA0, 8'h5a, rd);
    // Two frame times with no start bit shows the sender really held off.
    repeat (320) @(posedge clk);
    access(1'b0, IDX_FILL, 8'h00, rd);
    check(rd, 8'h10);
    check(remote.n_got, n0);
    remote.stop_sender <= 1'b0;
    wait_frame(n0);
    check(remote.got, 8'h5a);
  endtask
  task automatic rx_and_rts();
    access(1'b1, IDX_RTS, 8'h81, rd);
    repeat (3) @(posedge clk);
    check({7'h00, rts_pin}, 8'h00);
    remote.send(8'h3c);
    for (int i = 0; i < 60 && rts_pin !== 1'b1; i++) @(posedge clk);
    check({7'h00, rts_pin}, 8'h01);
    access(1'b0, IDX_FILL, 8'h00, rd);
    check(rd, 8'h01);
    access(1'b0, IDX_DATA0, 8'h00, rd);
    check(rd, 8'h3c);
    repeat (4) @(posedge clk);
    check({7'h00, rts_pin}, 8'h00);
    remote.send(8'h81);
    // Gap limit is twice the reset base of 192 ticks: quiet at 260, done by 410.
    repeat (260) @(posedge clk);
    access(1'b0, IDX_EVT, 8'h00, rd);
    check(rd, 8'h03);
    repeat (150) @(posedge clk);
    access(1'b0, IDX_EVT, 8'h00, rd);
    check(rd, 8'h07);
    access(1'b1, IDX_BUF, 8'h40, rd);
    access(1'b0, IDX_FILL, 8'h00, rd);
    check(rd, 8'h00);
  endtask
  task automatic manual_rts();
    access(1'b1, IDX_RTS, 8'he0, rd);
    repeat (3) @(posedge clk);
    check({7'h00, rts_pin}, 8'h01);
    access(1'b1, IDX_RTS, 8'hc0, rd);
    repeat (3) @(posedge clk);
    check({7'h00, rts_pin}, 8'h00);
  endtask
  // The shared line is driven only while the transmit level is low.
  task automatic smart_card();
    access(1'b1, IDX_TO_MODE, 8'h21, rd);
    @(posedge clk);
    check({7'h00, sc_en}, 8'h01);
    check({7'h00, trx_oe}, 8'h00);
    access(1'b1, IDX_DATA0, 8'h00, rd);
    repeat (5) @(posedge clk);
    check({7'h00, trx_oe}, 8'h01);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    reset_values();
    tx_frame();
    cts_hold();
    rx_and_rts();
    manual_rts();
    smart_card();
    conclude();
  end
endmodule
`default_nettype wire
